// [hdl/clock_ratio_reset_sequencer.sv]
// Purpose: core reset delay, multiplier selection and derived clock ratios
// Assumes: reference clock and reset pin are synchronous to clock
// Notes: derived clocks appear as one-cycle ticks and registered levels; the peripheral clock as a tick only
`include "clock_ratio_defines.svh"
module clock_ratio_reset_sequencer (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic reference_clock_in,
	input wire logic resetPin_n,
	input wire logic [1:0] ratio_select_pins,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic coreReset,
	output logic pllLocked,
	output logic [5:0] coreMultiplier,
	output logic peripheralTick,
	output logic sdramTick,
	output logic sdram_clock,
	output logic [1:0] serialTick,
	output logic [1:0] serialClock,
	output logic spiTick,
	output logic spi_serial_clock
);
	// byte-lane merge used by every writable register
	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] din, input logic [3:0] sel);
		laneMerge = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				laneMerge[i*8 +: 8] = din[i*8 +: 8];
			end
		end
	endfunction : laneMerge

	// multiplier chosen by the ratio pins
	function automatic logic [5:0] pinMult(input logic [1:0] pins);
		case (pins)
			2'h0: pinMult = `MULT_PINS00;
			2'h1: pinMult = `MULT_PINS01;
			2'h2: pinMult = `MULT_PINS10;
			default: pinMult = `MULT_PINS11;
		endcase
	endfunction : pinMult

	logic rstMeta_ff;
	logic rstSync_ff;
	logic refPrev_ff;
	logic refTick;
	logic [9:0] lockCnt_ff;
	logic locked_ff;
	clock_ratio_pkg::seq_state_t state_ff;
	clock_ratio_pkg::seq_state_t nxt_state;
	logic [12:0] refCnt_ff;
	logic [1:0] tailCnt_ff;
	logic [31:0] powerCtl_ff;
	logic [31:0] sdiv0_ff;
	logic [31:0] sdiv1_ff;
	logic [31:0] spi_baud_register_ff;
	logic [31:0] wb_dat_o_ff;
	logic wb_ack_o_ff;
	logic access;
	logic wrStrobe;
	logic [31:0] readMux;
	logic [15:0] sdramRatio;
	logic [1:0] serialLevel;
	logic [1:0] serialTickW;

	// reset pin synchroniser; first stage feeds only the second
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			rstMeta_ff <= 1'b0;
			rstSync_ff <= 1'b0;
			refPrev_ff <= 1'b0;
		end else begin
			rstMeta_ff <= resetPin_n;
			rstSync_ff <= rstMeta_ff;
			refPrev_ff <= reference_clock_in;
		end
	end

	// rising edge of the reference clock counts one reference period
	assign refTick = reference_clock_in && !refPrev_ff; // see [RL14]

	// lock timer from power-up; also gates the hold to count step, software may poll it  see [RL4]
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			lockCnt_ff <= 10'h000;
			locked_ff <= 1'b0;
		end else if (!locked_ff) begin
			lockCnt_ff <= lockCnt_ff + 10'h001;
			locked_ff <= (lockCnt_ff == 10'(`LOCK_CYCLES - 1));
		end
	end

	// sequencer next state; any reset pin assertion returns to hold
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			clock_ratio_pkg::SEQ_HOLD: begin
				if (rstSync_ff && locked_ff) begin
					nxt_state = clock_ratio_pkg::SEQ_COUNT;
				end
			end
			clock_ratio_pkg::SEQ_COUNT: begin
				if (refTick && refCnt_ff == `REF_HOLD_PERIODS - 13'h0001) begin
					nxt_state = clock_ratio_pkg::SEQ_TAIL; // see [RL1]
				end
			end
			clock_ratio_pkg::SEQ_TAIL: begin
				if (tailCnt_ff == `CORE_TAIL_CYCLES - 2'h1) begin
					nxt_state = clock_ratio_pkg::SEQ_RUN; // see [RL1]
				end
			end
			clock_ratio_pkg::SEQ_RUN: nxt_state = clock_ratio_pkg::SEQ_RUN;
			default: nxt_state = clock_ratio_pkg::SEQ_HOLD;
		endcase
		if (!rstSync_ff) begin
			nxt_state = clock_ratio_pkg::SEQ_HOLD;
		end
	end

	// the two-stage sync may add one reference period, 4097 at most  see [RL2]
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_ff <= clock_ratio_pkg::SEQ_HOLD;
			refCnt_ff <= 13'h0000;
			tailCnt_ff <= 2'h0;
		end else begin
			state_ff <= nxt_state;
			refCnt_ff <= (state_ff != clock_ratio_pkg::SEQ_COUNT) ? 13'h0000 : refCnt_ff + {12'h000, refTick};
			tailCnt_ff <= (state_ff != clock_ratio_pkg::SEQ_TAIL) ? 2'h0 : tailCnt_ff + 2'h1;
		end
	end

	assign coreReset = (state_ff != clock_ratio_pkg::SEQ_RUN); // see [RL1]
	assign pllLocked = locked_ff;

	// bus decode
	assign access = wb_cyc_i && wb_stb_i && !wb_ack_o_ff;
	assign wrStrobe = access && wb_we_i;

	// control registers; pins own the multiplier while reset pin is low
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			powerCtl_ff <= `PM_RESET;
			sdiv0_ff <= {16'h0000, `DIV_RESET};
			sdiv1_ff <= {16'h0000, `DIV_RESET};
			spi_baud_register_ff <= {16'h0000, `DIV_RESET};
		end else begin
			if (!rstSync_ff) begin
				powerCtl_ff[`PM_MULT_MSB:`PM_MULT_LSB] <= pinMult(ratio_select_pins); // see [RL13] see [RL12]
			end else if (wrStrobe && wb_adr_i == `REG_POWER_CTL) begin
				powerCtl_ff <= laneMerge(powerCtl_ff, wb_dat_i, wb_sel_i) & 32'h001C_003F; // see [RL13]
			end
			if (wrStrobe && wb_adr_i == `REG_SDIV0) begin
				sdiv0_ff <= laneMerge(sdiv0_ff, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
			end
			if (wrStrobe && wb_adr_i == `REG_SDIV1) begin
				sdiv1_ff <= laneMerge(sdiv1_ff, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
			end
			if (wrStrobe && wb_adr_i == `REG_SPI_BAUD) begin
				spi_baud_register_ff <= laneMerge(spi_baud_register_ff, wb_dat_i, wb_sel_i) & 32'h0000_FFFF;
			end
		end
	end

	// read mux; unmapped offsets read zero
	assign readMux = (wb_adr_i == `REG_POWER_CTL) ? powerCtl_ff :
		(wb_adr_i == `REG_SDIV0) ? sdiv0_ff :
		(wb_adr_i == `REG_SDIV1) ? sdiv1_ff :
		(wb_adr_i == `REG_SPI_BAUD) ? spi_baud_register_ff :
		(wb_adr_i == `REG_STATUS) ? {30'h0000_0000, locked_ff, coreReset} : 32'h0000_0000;

	// one ack per request, dropped the cycle after
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			wb_ack_o_ff <= 1'b0;
			wb_dat_o_ff <= 32'h0000_0000;
		end else begin
			wb_ack_o_ff <= access;
			if (access && !wb_we_i) begin
				wb_dat_o_ff <= readMux;
			end
		end
	end

	assign wb_ack_o = wb_ack_o_ff;
	assign wb_dat_o = wb_dat_o_ff;
	assign coreMultiplier = powerCtl_ff[`PM_MULT_MSB:`PM_MULT_LSB];
	assign sdramRatio = {13'h0000, powerCtl_ff[`PM_SDRAM_MSB:`PM_SDRAM_LSB]};

	// peripheral clock: core clock divided by two  see [RL7]
	ratio_divider periphDiv (
		.clock(clock), .sys_rst(sys_rst), .tickIn(1'b1), .ratio(`PERIPH_RATIO),
		.tickOut(peripheralTick), .levelOut()
	);

	// SDRAM clock from core clock and control bits 20-18  see [RL8]
	ratio_divider sdramDiv (
		.clock(clock), .sys_rst(sys_rst), .tickIn(1'b1), .ratio(sdramRatio),
		.tickOut(sdramTick), .levelOut(sdram_clock)
	);

	// serial port clocks from peripheral clock and divider fields  see [RL9]
	ratio_divider serialDiv0 (
		.clock(clock), .sys_rst(sys_rst), .tickIn(peripheralTick), .ratio(sdiv0_ff[15:0]),
		.tickOut(serialTickW[0]), .levelOut(serialLevel[0])
	);
	ratio_divider serialDiv1 (
		.clock(clock), .sys_rst(sys_rst), .tickIn(peripheralTick), .ratio(sdiv1_ff[15:0]),
		.tickOut(serialTickW[1]), .levelOut(serialLevel[1])
	);
	assign serialTick = serialTickW;
	assign serialClock = serialLevel;

	// SPI clock from peripheral clock and baud register  see [RL10]
	ratio_divider spiDiv (
		.clock(clock), .sys_rst(sys_rst), .tickIn(peripheralTick), .ratio(spi_baud_register_ff[15:0]),
		.tickOut(spiTick), .levelOut(spi_serial_clock)
	);
endmodule : clock_ratio_reset_sequencer

// [hdl/ratio_divider.sv]
// Purpose: divides a tick stream by a programmable ratio
// Assumes: ratio of zero behaves as one
// Notes: level output is high for the first half of each output period, rounded down; at a ratio of one it toggles on every tick
`include "clock_ratio_defines.svh"
module ratio_divider (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic tickIn,
	input wire logic [15:0] ratio,
	output logic tickOut,
	output logic levelOut
);
	logic [15:0] cnt_ff;
	logic [15:0] nxt_cnt;
	logic [15:0] lastCount;
	logic wrap;
	logic levelOut_ff;

	// terminal count and wrap
	assign lastCount = (ratio == 16'h0000) ? 16'h0000 : ratio - 16'h0001;
	assign wrap = tickIn && (cnt_ff >= lastCount);
	assign nxt_cnt = wrap ? 16'h0000 : cnt_ff + 16'h0001;
	assign tickOut = wrap;
	assign levelOut = levelOut_ff;

	// synchronous counter on the incoming tick  see [RL14]
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= 16'h0000;
			levelOut_ff <= 1'b0;
		end else if (tickIn) begin
			cnt_ff <= nxt_cnt;
			levelOut_ff <= (nxt_cnt < {1'b0, ratio[15:1]}) || (lastCount == 16'h0000 && !levelOut_ff);
		end
	end
endmodule : ratio_divider

// [include/clock_ratio_defines.svh]
// Purpose: constants for the clock ratio and reset sequencer
// Assumes: 10 MHz system clock stands in for the core clock
// Notes: register offsets are byte addresses on a 32-bit classic bus
// Function
// [RL1] after reset pin release, hold core reset 4096 reference periods plus two core clocks
// [RL2] a late reset release may slip one reference cycle, at most 4097 cycles
// [RL3] later resets keep the reset pin low at least four reference cycles
// [RL4] PLL needs up to 100 us lock with reset held low
// [RL5] reference clock stable at least 10 us before reset release
// [RL6] ratio pins settled 20 us before reset release, counted in reference cycles
// [RL7] peripheral clock is core clock divided by two
// [RL8] SDRAM clock is core clock times ratio from control bits 20-18
// [RL9] each serial port clock is peripheral clock times its divider field
// [RL10] SPI clock is peripheral clock times the baud register ratio
// [RL11] software keeps core clock period between 3.75 ns and 10 ns
// [RL12] ratio pins 00 and 01 select different multipliers
// [RL13] ratio pins set multiplier during reset; software may change it later
// [RL14] reset delay counts reference clocks; dividers are synchronous core-clock counters
`ifndef CLOCK_RATIO_DEFINES_SVH
`define CLOCK_RATIO_DEFINES_SVH
`define CLK_MHZ 10
`define LOCK_TIME_US 100
`define LOCK_CYCLES (`LOCK_TIME_US * `CLK_MHZ)
`define REF_HOLD_PERIODS 13'h1000
`define CORE_TAIL_CYCLES 2'h2
`define REG_POWER_CTL 5'h00
`define REG_SDIV0 5'h04
`define REG_SDIV1 5'h08
`define REG_SPI_BAUD 5'h0C
`define REG_STATUS 5'h10
`define PM_MULT_LSB 0
`define PM_MULT_MSB 5
`define PM_SDRAM_LSB 18
`define PM_SDRAM_MSB 20
`define PM_RESET 32'h0000_0000
`define DIV_RESET 16'h0004
`define MULT_PINS00 6'h06
`define MULT_PINS01 6'h20
`define MULT_PINS10 6'h10
`define MULT_PINS11 6'h06
`define PERIPH_RATIO 16'h0002
`endif

// [include/clock_ratio_pkg.sv]
// Purpose: shared types for the clock ratio and reset sequencer
// Assumes: nothing beyond standard SystemVerilog
// Notes: states are one-hot
package clock_ratio_pkg;
	typedef enum logic [3:0] {
		SEQ_HOLD = 4'h1,
		SEQ_COUNT = 4'h2,
		SEQ_TAIL = 4'h4,
		SEQ_RUN = 4'h8
	} seq_state_t;
endpackage : clock_ratio_pkg

// [testbench/clock_ratio_properties.sv]
// Purpose: timing checks of the sequencer ports
// Assumes: one clock domain
// Notes: counts reference edges while the reset pin is high
module clock_ratio_properties (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic reference_clock_in,
	input wire logic resetPin_n,
	input wire logic [1:0] ratio_select_pins,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [4:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic coreReset,
	input wire logic [5:0] coreMultiplier,
	input wire logic peripheralTick
);
	timeunit 1ns;
	timeprecision 1ns;
	logic refPrev_ff;
	int refCnt_ff;
	logic [5:0] pinMult;
	// reference rising edges since pin release
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			refPrev_ff <= 1'b0;
			refCnt_ff <= 0;
		end else begin
			refPrev_ff <= reference_clock_in;
			refCnt_ff <= resetPin_n ? refCnt_ff + int'(reference_clock_in && !refPrev_ff) : 0;
		end
	end
	// multiplier the pins select
	assign pinMult = (ratio_select_pins == 2'h1) ? 6'h20 : (ratio_select_pins == 2'h2) ? 6'h10 : 6'h06;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	periph_half_a: assert property (peripheralTick |=> !peripheralTick ##1 peripheralTick)
		else $error("peripheral tick spacing");
	core_delay_a: assert property ($fell(coreReset) |-> refCnt_ff inside {[4096:4097]})
		else $error("core reset delay");
	core_rearm_a: assert property ($fell(resetPin_n) |-> ##[1:4] coreReset)
		else $error("core reset not rearmed");
	pin_mult_a: assert property ((!resetPin_n && $stable(ratio_select_pins))[*4] |-> coreMultiplier == pinMult)
		else $error("pin multiplier");
	mult_hold_a: assert property (resetPin_n[*4] ##0 !(wb_stb_i && wb_we_i) |=> $stable(coreMultiplier))
		else $error("multiplier changed");
	ack_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	unmapped_a: assert property (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o && wb_adr_i > 5'h10 |=> wb_dat_o == 32'h0)
		else $error("unmapped read data");
	cover property ($fell(coreReset));
	cover property (ratio_select_pins == 2'h1 && !resetPin_n);
	cover property (wb_ack_o && wb_adr_i == 5'h14);
endmodule : clock_ratio_properties

// [testbench/reference_source.sv]
// Purpose: board oscillator and reset source
// Assumes: reference clock is slow against clock
// Notes: oscillator runs free; pin low at least LOW_MIN reference edges, which also covers ratio pin settling
module reference_source #(parameter int HALF = 4, parameter int LOW_MIN = 4) (
	input wire logic clock,
	input wire logic hold,
	output logic refClock,
	output logic resetPin_n
);
	timeunit 1ns;
	timeprecision 1ns;
	int ph = 0;
	int lows = 0;
	initial refClock = 1'b0;
	initial resetPin_n = 1'b0;
	// stable free running reference
	always @(posedge clock) begin
		ph <= (ph == HALF - 1) ? 0 : ph + 1;
		if (ph == HALF - 1) refClock <= ~refClock;
	end
	// release only after enough reference edges low
	always @(posedge clock) begin
		lows <= resetPin_n ? 0 : lows + int'(ph == HALF - 1 && !refClock);
		if (hold) resetPin_n <= 1'b0;
		else if (lows >= LOW_MIN) resetPin_n <= 1'b1;
	end
endmodule : reference_source

// [testbench/testbench.sv]
// Purpose: self checking bench of the sequencer
// Assumes: reference period of eight clocks
// Notes: bus results checked from a queue
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0, sys_rst = 1'b1, hold = 1'b1, reference_clock_in, resetPin_n;
	logic [1:0] ratio_select_pins = 2'h0, serialTick, serialClock;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, coreReset, pllLocked;
	logic [4:0] wb_adr_i = 5'h00, tk, lv;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
	logic peripheralTick, sdramTick, sdram_clock, spiTick, spi_serial_clock;
	logic [5:0] coreMultiplier, mult[4] = '{6'h06, 6'h20, 6'h10, 6'h06};
	logic [63:0] q[$], e;
	int n_fail = 0, compares = 0;
	assign tk = {spiTick, serialTick, sdramTick, peripheralTick};
	// derived clock levels; the peripheral level is not brought out
	assign lv = {spi_serial_clock, serialClock, sdram_clock, 1'b0};
	always #50 clock = ~clock;
	// 26 reference edges low give 25 full periods, 20 us, for pins set with the pin assertion
	reference_source #(.HALF(4), .LOW_MIN(26)) src (.clock, .hold, .refClock(reference_clock_in), .resetPin_n);
	clock_ratio_reset_sequencer DUT (.clock, .sys_rst, .reference_clock_in, .resetPin_n, .ratio_select_pins,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .coreReset,
		.pllLocked, .coreMultiplier, .peripheralTick, .sdramTick, .sdram_clock, .serialTick, .serialClock,
		.spiTick, .spi_serial_clock);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask : check
	// one classic cycle; notes expected data under mask m
	task automatic xfer(input logic we, input logic [4:0] a, input logic [31:0] d, input logic [31:0] m);
		q.push_back({d & m, m});
		@(posedge clock);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do @(posedge clock); while (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask : xfer
	// clocks between two ticks of tk[k], and how many of them see lv[k] high
	task automatic gap(input int k, input int exp, input int hi);
		int n = 0;
		int h = 0;
		repeat (2) @(posedge clock iff tk[k] === 1'b1);
		do begin
			@(posedge clock);
			n++;
			h += int'(lv[k] === 1'b1);
		end while (tk[k] !== 1'b1);
		check(n, exp);
		check(h, hi);
	endtask : gap
	task automatic waitCore;
		int i = 0;
		wait (resetPin_n === 1'b1);
		while (coreReset !== 1'b0 && i < 34000) begin
			@(posedge clock);
			i++;
		end
		check(32'(i >= 4095 * 8 && i <= 4097 * 8 + 6), 32'h1);
	endtask : waitCore
	task summarize;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : summarize
	// compares each acknowledge with the oldest note
	always @(posedge clock) begin
		if (wb_ack_o === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			check(wb_dat_o & e[31:0], e[63:32]);
		end
	end
	initial begin
		repeat (90000) @(posedge clock);
		n_fail++;
		summarize;
	end
	initial begin
		void'($urandom(54193));
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		for (int p = 0; p < 4; p++) begin
			ratio_select_pins <= 2'(p);
			repeat (6) @(posedge clock);
			check(coreMultiplier, mult[p]);
		end
		xfer(1'b1, 5'h00, $urandom, 32'h0);
		xfer(1'b0, 5'h00, 32'h6, '1);
		xfer(1'b0, 5'h04, 32'h4, '1);
		xfer(1'b0, 5'h14, 32'h0, '1);
		wait (pllLocked === 1'b1);
		hold <= 1'b0;
		waitCore;
		xfer(1'b0, 5'h10, 32'h2, '1);
		xfer(1'b1, 5'h00, ($urandom & 32'hFFE3FFC0) | 32'h000C0010, 32'h0);
		xfer(1'b0, 5'h00, 32'h000C0010, '1);
		xfer(1'b1, 5'h04, ($urandom & 32'hFFFF0000) | 32'h5, 32'h0);
		xfer(1'b1, 5'h08, 32'h3, 32'h0);
		xfer(1'b1, 5'h0C, 32'h7, 32'h0);
		xfer(1'b0, 5'h04, 32'h5, '1);
		gap(0, 2, 0);
		gap(1, 3, 1);
		gap(2, 10, 4);
		gap(3, 6, 2);
		gap(4, 14, 6);
		// pins change together with the pin assertion; the long low time lets them settle
		ratio_select_pins <= 2'h1;
		hold <= 1'b1;
		wait (resetPin_n === 1'b0);
		repeat (4) @(posedge clock);
		check(coreReset, 32'h1);
		hold <= 1'b0;
		waitCore;
		check(coreMultiplier, 32'h20);
		summarize;
	end
endmodule : testbench
bind clock_ratio_reset_sequencer clock_ratio_properties chk (.clock, .sys_rst, .reference_clock_in, .resetPin_n,
	.ratio_select_pins, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .coreReset,
	.coreMultiplier, .peripheralTick);
